// ### hdl/dps_axil_wr.v
`timescale 1ns/1ps
`include "dps_regs.vh"

module dps_axil_wr (
  input wire clk, // System clock
  input wire rst, // Synchronous reset, high
  input wire awvalid, // Write address valid
  output reg awready, // Write address ready
  input wire aw_mapped, // Address hits a shadow register
  input wire wvalid, // Write data valid
  output reg wready, // Write data ready
  output reg bvalid, // Write response valid
  input wire bready, // Write response ready
  output reg [1:0] bresp // Write response code
);

  reg aw_got;
  reg w_got;
  wire aw_hit;
  wire w_hit;
  wire aw_n;
  wire w_n;

  // Address and data may be taken in either order
  assign aw_hit = awvalid & awready;
  assign w_hit = wvalid & wready;
  assign aw_n = aw_got | aw_hit;
  assign w_n = w_got | w_hit;

  // Every write is dropped; mapped ones answer SLVERR so software sees they did nothing
  always @(posedge clk) begin
    if (rst) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `DPS_RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
    end else if (bvalid) begin
      if (bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end else begin
      if (aw_hit) begin
        bresp <= aw_mapped ? `DPS_RESP_SLVERR : `DPS_RESP_DECERR;
      end
      if (aw_n & w_n) begin
        bvalid <= 1'b1;
        aw_got <= 1'b0;
        w_got <= 1'b0;
        awready <= 1'b0;
        wready <= 1'b0;
      end else begin
        aw_got <= aw_n;
        w_got <= w_n;
        awready <= ~aw_n;
        wready <= ~w_n;
      end
    end
  end

endmodule

// ### hdl/dps_regs.vh
`ifndef DPS_REGS_VH
`define DPS_REGS_VH

// ****************************************
// Bus geometry
// ****************************************
`define DPS_ADDR_W 16
`define DPS_NUM_REGS 14
`define DPS_IDX_W 4
`define DPS_IDX_NONE 4'hf

// ****************************************
// Register byte offsets
// ****************************************
`define DPS_OFF_ODT_RD_LO 16'h1368
`define DPS_OFF_ODT_RD_HI 16'h136c
`define DPS_OFF_DQ_A 16'h1380
`define DPS_OFF_DQ_B 16'h1384
`define DPS_OFF_DQ_C 16'h1388
`define DPS_OFF_DQ_D 16'h138c
`define DPS_OFF_DQ_CHK 16'h1390
`define DPS_OFF_ODT_RANK 16'h13b0
`define DPS_OFF_USER0 16'h1408
`define DPS_OFF_USER1 16'h140c
`define DPS_OFF_RESP_DLY 16'h1610
`define DPS_OFF_DISC_TO 16'h1614
`define DPS_OFF_ODT_WR 16'h13b4
`define DPS_OFF_WDQ_CTRL 16'h1620

// ****************************************
// Register indices into the shadow bank
// ****************************************
`define DPS_IX_ODT_RD_LO 4'h0
`define DPS_IX_ODT_RD_HI 4'h1
`define DPS_IX_DQ_A 4'h2
`define DPS_IX_DQ_B 4'h3
`define DPS_IX_DQ_C 4'h4
`define DPS_IX_DQ_D 4'h5
`define DPS_IX_DQ_CHK 4'h6
`define DPS_IX_ODT_RANK 4'h7
`define DPS_IX_USER0 4'h8
`define DPS_IX_USER1 4'h9
`define DPS_IX_RESP_DLY 4'ha
`define DPS_IX_DISC_TO 4'hb
`define DPS_IX_ODT_WR 4'hc
`define DPS_IX_WDQ_CTRL 4'hd

// ****************************************
// Reset values
// ****************************************
`define DPS_RST_ZERO 32'h00000000
`define DPS_RST_DISC_TO 32'h0000000f

// ****************************************
// Controller state codes
// ****************************************
`define DPS_ST_W 3
`define DPS_ST_CONFIG 3'h0
`define DPS_ST_LOW_POWER 3'h1
`define DPS_ST_PAUSED 3'h2

// ****************************************
// AXI responses
// ****************************************
`define DPS_RESP_OKAY 2'h0
`define DPS_RESP_SLVERR 2'h2
`define DPS_RESP_DECERR 2'h3

`endif

// ### hdl/dps_shadow_regs.v
`timescale 1ns/1ps
`include "dps_regs.vh"

module dps_shadow_regs (
  input wire clk, // System clock, 100 MHz
  input wire rst, // Synchronous reset, high
  input wire [`DPS_ST_W-1:0] ctrl_state, // Controller state code
  input wire [31:0] pend_odt_rd_lo, // Programmed read ODT control, low word
  input wire [31:0] pend_odt_rd_hi, // Programmed read ODT control, high word
  input wire [31:0] pend_dq_a, // Programmed DQ map, nibble word a
  input wire [31:0] pend_dq_b, // Programmed DQ map, nibble word b
  input wire [31:0] pend_dq_c, // Programmed DQ map, nibble word c
  input wire [31:0] pend_dq_d, // Programmed DQ map, nibble word d
  input wire [31:0] pend_dq_chk, // Programmed DQ map, check bits
  input wire [31:0] pend_odt_rank, // Programmed ODT rank map
  input wire [31:0] pend_user0, // Programmed user word 0
  input wire [31:0] pend_user1, // Programmed user word 1
  input wire [31:0] pend_resp_dly, // Programmed training response delay
  input wire [31:0] pend_disc_to, // Programmed disconnect timeout
  input wire [31:0] pend_odt_wr, // Programmed ODT write map
  input wire [31:0] pend_wdq_ctrl, // Programmed write-DQ training control
  output wire [31:0] odt_read_ctrl_low, // Active read ODT, low word
  output wire [31:0] odt_read_ctrl_high, // Active read ODT, high word
  output wire [127:0] dq_bitmap_nibbles, // Active DQ map, words d,c,b,a
  output wire [31:0] dq_bitmap_checkbits, // Active DQ map, check bits
  output wire [31:0] odt_pin_rank_map, // Active ODT rank map
  output wire [31:0] odt_pin_write_map, // Active ODT write map
  output wire [31:0] user_output_word0, // User output word 0
  output wire [31:0] user_output_word1, // User output word 1
  output wire [31:0] buffer_train_resp_delay, // Active response delay
  output wire [31:0] train_disconnect_timeout, // Active disconnect timeout
  output wire [31:0] write_dq_train_ctrl, // Active write-DQ training control
  input wire [`DPS_ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire [2:0] s_axi_awprot, // Write protection, unused
  input wire s_axi_awvalid, // Write address valid
  output wire s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data, ignored
  input wire [3:0] s_axi_wstrb, // Write strobes, ignored
  input wire s_axi_wvalid, // Write data valid
  output wire s_axi_wready, // Write data ready
  output wire [1:0] s_axi_bresp, // Write response
  output wire s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [`DPS_ADDR_W-1:0] s_axi_araddr, // Read address
  input wire [2:0] s_axi_arprot, // Read protection, unused
  input wire s_axi_arvalid, // Read address valid
  output reg s_axi_arready, // Read address ready
  output reg [31:0] s_axi_rdata, // Read data
  output reg [1:0] s_axi_rresp, // Read response
  output reg s_axi_rvalid, // Read data valid
  input wire s_axi_rready // Read data ready
);

  // ****************************************
  // Decoding
  // ****************************************

  // Byte address to shadow index; unmapped gives the none code
  function [`DPS_IDX_W-1:0] dps_index;
    input [`DPS_ADDR_W-1:0] addr;
    begin
      case (addr)
        `DPS_OFF_ODT_RD_LO: dps_index = `DPS_IX_ODT_RD_LO;
        `DPS_OFF_ODT_RD_HI: dps_index = `DPS_IX_ODT_RD_HI;
        `DPS_OFF_DQ_A: dps_index = `DPS_IX_DQ_A;
        `DPS_OFF_DQ_B: dps_index = `DPS_IX_DQ_B;
        `DPS_OFF_DQ_C: dps_index = `DPS_IX_DQ_C;
        `DPS_OFF_DQ_D: dps_index = `DPS_IX_DQ_D;
        `DPS_OFF_DQ_CHK: dps_index = `DPS_IX_DQ_CHK;
        `DPS_OFF_ODT_RANK: dps_index = `DPS_IX_ODT_RANK;
        `DPS_OFF_USER0: dps_index = `DPS_IX_USER0;
        `DPS_OFF_USER1: dps_index = `DPS_IX_USER1;
        `DPS_OFF_RESP_DLY: dps_index = `DPS_IX_RESP_DLY;
        `DPS_OFF_DISC_TO: dps_index = `DPS_IX_DISC_TO;
        `DPS_OFF_ODT_WR: dps_index = `DPS_IX_ODT_WR;
        `DPS_OFF_WDQ_CTRL: dps_index = `DPS_IX_WDQ_CTRL;
        default: dps_index = `DPS_IDX_NONE;
      endcase
    end
  endfunction

  // Reset value of each shadow, by index
  function [31:0] dps_reset_val;
    input integer idx;
    begin
      if (idx == `DPS_IX_DISC_TO) begin
        dps_reset_val = `DPS_RST_DISC_TO;
      end else begin
        dps_reset_val = `DPS_RST_ZERO;
      end
    end
  endfunction

  // User words follow the programmed value in every state
  function dps_always_live;
    input integer idx;
    begin
      dps_always_live = (idx == `DPS_IX_USER0) || (idx == `DPS_IX_USER1);
    end
  endfunction

  // ****************************************
  // Shadow bank
  // ****************************************

  wire [`DPS_NUM_REGS*32-1:0] pend_flat;
  wire [`DPS_NUM_REGS*32-1:0] shadow_flat;
  wire state_quiet;
  wire [`DPS_IDX_W-1:0] ar_idx;
  wire [`DPS_IDX_W-1:0] aw_idx;

  // Programmed words packed by index, highest index first
  assign pend_flat = {pend_wdq_ctrl, pend_odt_wr, pend_disc_to, pend_resp_dly,
                      pend_user1, pend_user0, pend_odt_rank, pend_dq_chk,
                      pend_dq_d, pend_dq_c, pend_dq_b, pend_dq_a,
                      pend_odt_rd_hi, pend_odt_rd_lo};

  // Traffic-sensitive settings move only while no DRAM traffic depends on them
  assign state_quiet = (ctrl_state == `DPS_ST_CONFIG) ||
                       (ctrl_state == `DPS_ST_LOW_POWER) ||
                       (ctrl_state == `DPS_ST_PAUSED);

  // One gated shadow word per register
  genvar gi;
  generate
    for (gi = 0; gi < `DPS_NUM_REGS; gi = gi + 1) begin : g_shadow
      dps_shadow_word #(
        .RESET_VAL(dps_reset_val(gi))
      ) u_word (
        .clk(clk),
        .rst(rst),
        .load_en(dps_always_live(gi) | state_quiet),
        .pend_val(pend_flat[gi*32 +: 32]),
        .shadow_reg(shadow_flat[gi*32 +: 32])
      );
    end
  endgenerate

  // ****************************************
  // Controller-facing outputs
  // ****************************************

  // Read termination settings for active and inactive ranks
  assign odt_read_ctrl_low = shadow_flat[`DPS_IX_ODT_RD_LO*32 +: 32];
  assign odt_read_ctrl_high = shadow_flat[`DPS_IX_ODT_RD_HI*32 +: 32];
  // Per-nibble map indices feed the CRC bit-order compensation
  assign dq_bitmap_nibbles = shadow_flat[`DPS_IX_DQ_A*32 +: 128];
  // Check-bit nibbles keep their own map; software must fill it correctly
  assign dq_bitmap_checkbits = shadow_flat[`DPS_IX_DQ_CHK*32 +: 32];
  // ODT line ownership per rank, and lines raised during writes
  assign odt_pin_rank_map = shadow_flat[`DPS_IX_ODT_RANK*32 +: 32];
  assign odt_pin_write_map = shadow_flat[`DPS_IX_ODT_WR*32 +: 32];
  // User words straight from their shadow flops
  assign user_output_word0 = shadow_flat[`DPS_IX_USER0*32 +: 32];
  assign user_output_word1 = shadow_flat[`DPS_IX_USER1*32 +: 32];
  // Response or read-data delay; must cover board round trip
  assign buffer_train_resp_delay = shadow_flat[`DPS_IX_RESP_DLY*32 +: 32];
  // Shared disconnect timeout for every training interface
  assign train_disconnect_timeout = shadow_flat[`DPS_IX_DISC_TO*32 +: 32];
  assign write_dq_train_ctrl = shadow_flat[`DPS_IX_WDQ_CTRL*32 +: 32];

  // ****************************************
  // AXI4-Lite write side
  // ****************************************

  assign aw_idx = dps_index(s_axi_awaddr);

  // Writes are answered but never reach the bank
  dps_axil_wr u_wr (
    .clk(clk),
    .rst(rst),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .aw_mapped(aw_idx != `DPS_IDX_NONE),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .bresp(s_axi_bresp)
  );

  // ****************************************
  // AXI4-Lite read side
  // ****************************************

  assign ar_idx = dps_index(s_axi_araddr);

  // One read in flight; data captured at the address handshake so it stays stable
  always @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `DPS_RST_ZERO;
      s_axi_rresp <= `DPS_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      if (ar_idx == `DPS_IDX_NONE) begin
        s_axi_rdata <= `DPS_RST_ZERO;
        s_axi_rresp <= `DPS_RESP_DECERR;
      end else begin
        s_axi_rdata <= shadow_flat[ar_idx*32 +: 32];
        s_axi_rresp <= `DPS_RESP_OKAY;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ### hdl/dps_shadow_word.v
`timescale 1ns/1ps
`include "dps_regs.vh"

module dps_shadow_word #(
  parameter [31:0] RESET_VAL = `DPS_RST_ZERO
) (
  input wire clk, // System clock
  input wire rst, // Synchronous reset, high
  input wire load_en, // Copy allowed this cycle
  input wire [31:0] pend_val, // Programmed value to mirror
  output reg [31:0] shadow_reg // Active value
);

  // Hold the active copy; only reset and the gate decide when it moves
  always @(posedge clk) begin
    if (rst) begin
      shadow_reg <= RESET_VAL;
    end else if (load_en) begin
      shadow_reg <= pend_val;
    end
  end

endmodule

// ### tb/dps_shadow_regs_asserts.sv
`timescale 1ns/1ps
module dps_chk (
  input logic clk, // Clock
  input logic rst, // Reset
  input logic [2:0] ctrl_state, // State code
  input logic [31:0] pend_user0, // Pending user word
  input logic [31:0] pend_odt_rank, // Pending rank map
  input logic [31:0] pend_disc_to, // Pending timeout
  input logic [31:0] user_output_word0, // User word
  input logic [31:0] odt_pin_rank_map, // Rank map
  input logic [31:0] train_disconnect_timeout, // Timeout
  input logic [31:0] odt_read_ctrl_low, // Read ODT low
  input logic [127:0] dq_bitmap_nibbles, // DQ maps
  input logic s_axi_arvalid, // Read address valid
  input logic s_axi_arready, // Read address ready
  input logic s_axi_rvalid, // Read valid
  input logic s_axi_rready, // Read ready
  input logic [31:0] s_axi_rdata, // Read data
  input logic [1:0] s_axi_rresp, // Read response
  input logic s_axi_wvalid, // Write data valid
  input logic s_axi_wready, // Write data ready
  input logic s_axi_bvalid, // Write response valid
  input logic [1:0] s_axi_bresp // Write response
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ****
  // Bus steps
  // ****
  sequence ar_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence r_take; s_axi_rvalid && s_axi_rready; endsequence
  sequence w_take; s_axi_wvalid && s_axi_wready; endsequence
  // Shadow loading; a frozen word must not drift while traffic runs
  a_user_follow: assert property (!$past(rst) |-> user_output_word0 == $past(pend_user0))
    else $error("user word did not follow its input");
  a_rank_load: assert property (ctrl_state <= 3'h2 |=> odt_pin_rank_map == $past(pend_odt_rank))
    else $error("rank map not loaded in a loading state");
  a_timeout_load: assert property (ctrl_state <= 3'h2 |=> train_disconnect_timeout == $past(pend_disc_to))
    else $error("timeout not loaded in a loading state");
  a_active_frozen: assert property (ctrl_state > 3'h2 |=> $stable(odt_read_ctrl_low) && $stable(dq_bitmap_nibbles))
    else $error("shadow changed in an active state");
  // Bus answers
  a_read_answer: assert property (ar_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered in one cycle");
  a_read_release: assert property (r_take |=> !s_axi_rvalid)
    else $error("read data held after it was taken");
  a_write_answer: assert property (w_take |-> ##[1:16] s_axi_bvalid)
    else $error("write never answered");
  a_write_refused: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h2, 2'h3})
    else $error("write accepted by a read-only bank");
  a_unmapped_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h3 |-> s_axi_rdata == 32'h0)
    else $error("unmapped read returned data");
endmodule
bind dps_shadow_regs dps_chk u_chk (.*);

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk, rst, run;
  logic [2:0] ctrl_state, s_axi_awprot, s_axi_arprot;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rv, d;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  logic [1:0] r;
  logic [31:0] pd [14];
  logic [31:0] ex [14];
  wire [31:0] q [14];
  wire [127:0] nib;
  logic [15:0] offs [14] = '{16'h1368, 16'h136c, 16'h1380, 16'h1384, 16'h1388, 16'h138c,
    16'h1390, 16'h13b0, 16'h1408, 16'h140c, 16'h1610, 16'h1614, 16'h13b4, 16'h1620};
  integer seed = 76363, failures = 0, n_checks = 0, cyc = 0, i;

  dps_shadow_regs dut (.pend_odt_rd_lo(pd[0]), .pend_odt_rd_hi(pd[1]), .pend_dq_a(pd[2]),
    .pend_dq_b(pd[3]), .pend_dq_c(pd[4]), .pend_dq_d(pd[5]), .pend_dq_chk(pd[6]),
    .pend_odt_rank(pd[7]), .pend_user0(pd[8]), .pend_user1(pd[9]), .pend_resp_dly(pd[10]),
    .pend_disc_to(pd[11]), .pend_odt_wr(pd[12]), .pend_wdq_ctrl(pd[13]),
    .odt_read_ctrl_low(q[0]), .odt_read_ctrl_high(q[1]),
    .dq_bitmap_nibbles(nib), .dq_bitmap_checkbits(q[6]),
    .odt_pin_rank_map(q[7]), .user_output_word0(q[8]), .user_output_word1(q[9]),
    .buffer_train_resp_delay(q[10]), .train_disconnect_timeout(q[11]),
    .odt_pin_write_map(q[12]), .write_dq_train_ctrl(q[13]), .*);

  // Split the wide map into words a..d through one net, not an array concatenation port
  assign {q[5], q[4], q[3], q[2]} = nib;

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  // ****
  // Stimulus and model
  // ****
  // Outside the random run the state stays active and user words hold, so reads are stable
  always @(posedge clk) begin
    rv = $random(seed);
    ctrl_state <= run ? rv[2:0] : 3'h4 + {1'b0, rv[1:0]};
    for (int k = 0; k < 14; k++)
      if (run || (k != 8 && k != 9)) pd[k] <= $random(seed);
  end

  // Reference bank; the cycle ceiling guards against a hung handshake
  always @(posedge clk) begin
    cyc <= cyc + 1;
    for (int k = 0; k < 14; k++)
      if (rst) ex[k] = (k == 11) ? 32'h0000000f : 32'h00000000;
      else if (k == 8 || k == 9 || ctrl_state <= 3'h2) ex[k] = pd[k];
    if (cyc > 20000) begin
      failures++;
      conclude;
    end
  end

  // Every shadow output against the model, settled at the falling edge
  always @(negedge clk)
    for (int k = 0; k < 14; k++) chk($sformatf("shadow%0d", k), ex[k], q[k]);

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task conclude;
    if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ****
  // Bus tasks
  // ****
  task automatic rd(input logic [15:0] a, output logic [31:0] dv, output logic [1:0] rs);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge clk);
    dv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, output logic [1:0] rs);
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= $random(seed);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    rst = 1;
    run = 0;
    ctrl_state = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awprot, s_axi_arprot} = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    for (i = 0; i < 14; i++) pd[i] = 32'h0;
    repeat (16) @(posedge clk);
    rst <= 0;
    run <= 1;
    repeat (400) @(posedge clk);
    run <= 0;
    repeat (3) @(posedge clk);
    for (i = 0; i < 14; i++) begin
      rd(offs[i], d, r);
      chk("rdata", ex[i], d);
      chk("rresp", 32'h0, {30'h0, r});
    end
    rd(16'h1000, d, r);
    chk("rresp", 32'h3, {30'h0, r});
    chk("rdata", 32'h0, d);
    rd(offs[2] + 16'h0002, d, r);
    chk("rdata", 32'h0, d);
    chk("rresp", 32'h3, {30'h0, r});
    for (i = 0; i < 14; i += 6) begin
      wr(offs[i], r);
      chk("bresp", 32'h2, {30'h0, r});
    end
    wr(16'h1ffc, r);
    chk("bresp", 32'h3, {30'h0, r});
    // A second reset in mid-run must restore the reset values
    rst <= 1;
    repeat (3) @(posedge clk);
    rst <= 0;
    // State stays active here, so the timeout must still read its reset value
    rd(offs[11], d, r);
    chk("rdata", 32'h0000000f, d);
    chk("rresp", 32'h0, {30'h0, r});
    run <= 1;
    repeat (100) @(posedge clk);
    conclude;
  end
endmodule
